// ===== mem_model.sv
`default_nettype none
module mem_model (
    // bus side
    input wire logic sys_clk_i,
    input wire logic [7:0] chip_select_n_i,
    input wire logic read_strobe_n_i,
    input wire logic write_strobe_n_i,
    input wire logic [23:0] addr_i,
    input wire logic [31:0] data_i,
    input wire logic data_oe_i,
    output logic [31:0] data_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] mem [16];
    logic sel;
    assign sel = ~&chip_select_n_i;
    // valid only while select and read strobe are both low, so a wrong sample edge reads garbage
    assign data_o = (sel && !read_strobe_n_i) ? mem[addr_i[3:0]] : ~mem[addr_i[3:0]];
    initial begin
        for (int i = 0; i < 16; i++) begin
            mem[i] = 32'h5a000000 + i;
        end
    end
    always @(posedge sys_clk_i) begin
        if (sel && !write_strobe_n_i && data_oe_i) mem[addr_i[3:0]] <= data_i;
    end
endmodule
`default_nettype wire

// ===== static_memory_strobe_timing.sv
`default_nettype none
// What this block does
// - 32-bit select: low address bits unused, low lines carry lane selects or strobes.
// - 16-bit select: address bit 0 unused, address bit 1 on third line.
// - 8-bit select: full address on shared lines, one write strobe.
// - byte-select leaves write strobes 1-3 unused; byte-write leaves lane selects unused.
// - lane selects follow address bus timing exactly.
// - byte write strobes share the single write strobe timing.
// - read strobe low after lead for width cycles; address held to cycle end.
// - chip select read timing is independent of read strobe timing.
// - read trails derive from cycle length minus lead minus width.
// - all timings kept per chip select in whole clock cycles.
// - zero lead and trail keep read strobes low across back-to-back reads.
// - only the read mode picks the sampling signal, no comparison.
// - read mode 1 samples at the read strobe rising edge.
// - read mode 0 samples at the chip select rising edge.
// - write strobe low after lead for width; address and data held through trail.
// - write chip select counts kept apart from read counts.
// - write trails derive from write cycle length.
// - zero lead and trail keep write strobes low across consecutive writes.
// - write mode 1 drives data from write strobe lead to cycle end.
// - write mode 0 drives data from chip select write lead to cycle end.
// - setup code top bit adds 128 to lower five bits.
// - reset timing gives three cycle accesses and chip-select control.
module static_memory_strobe_timing #(
    parameter int NSEL = strobe_timing_pkg::NUM_SELECTS
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // per-select configuration, one slice per chip select
    input wire logic [NSEL*strobe_timing_pkg::SETUP_W-1:0] read_strobe_lead_i,
    input wire logic [NSEL*strobe_timing_pkg::PULSE_W-1:0] read_strobe_width_i,
    input wire logic [NSEL*strobe_timing_pkg::SETUP_W-1:0] select_read_lead_i,
    input wire logic [NSEL*strobe_timing_pkg::PULSE_W-1:0] select_read_width_i,
    input wire logic [NSEL*strobe_timing_pkg::CYCLE_W-1:0] read_cycle_length_i,
    input wire logic [NSEL*strobe_timing_pkg::SETUP_W-1:0] write_strobe_lead_i,
    input wire logic [NSEL*strobe_timing_pkg::PULSE_W-1:0] write_strobe_width_i,
    input wire logic [NSEL*strobe_timing_pkg::SETUP_W-1:0] select_write_lead_i,
    input wire logic [NSEL*strobe_timing_pkg::PULSE_W-1:0] select_write_width_i,
    input wire logic [NSEL*strobe_timing_pkg::CYCLE_W-1:0] write_cycle_length_i,
    input wire logic [NSEL-1:0] read_mode_i,
    input wire logic [NSEL-1:0] write_mode_i,
    input wire logic [NSEL*2-1:0] bus_width_i,
    input wire logic [NSEL-1:0] byte_access_type_i,
    // access request
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic [strobe_timing_pkg::SEL_W-1:0] req_sel_i,
    input wire logic [strobe_timing_pkg::ADDR_W-1:0] req_addr_i,
    input wire logic [strobe_timing_pkg::DATA_W-1:0] req_wdata_i,
    input wire logic [3:0] req_lanes_i,
    output logic req_ready_o,
    output logic rdata_valid_o,
    output logic [strobe_timing_pkg::DATA_W-1:0] rdata_o,
    // memory pins
    output logic [NSEL-1:0] chip_select_n_o,
    output logic read_strobe_n_o,
    output logic write_strobe_n_o,
    output logic byte_lane_select0_n_o,
    output logic byte_lane_select1_n_o,
    output logic byte_lane_select2_n_o,
    output logic byte_lane_select3_n_o,
    output logic [strobe_timing_pkg::ADDR_W-1:2] addr_o,
    input wire logic [strobe_timing_pkg::DATA_W-1:0] data_i,
    output logic [strobe_timing_pkg::DATA_W-1:0] data_o,
    output logic data_oe_o
);
    localparam int CW = strobe_timing_pkg::COUNT_W;

    function automatic logic [CW-1:0] exp_setup(input logic [strobe_timing_pkg::SETUP_W-1:0] c);
        exp_setup = CW'(c[4:0]) + (c[strobe_timing_pkg::SETUP_HI_BIT]
            ? CW'(strobe_timing_pkg::SETUP_HI_WEIGHT) : '0);
    endfunction
    function automatic logic [CW-1:0] exp_pulse(input logic [strobe_timing_pkg::PULSE_W-1:0] c);
        exp_pulse = CW'(c[5:0]) + (c[strobe_timing_pkg::PULSE_HI_BIT]
            ? CW'(strobe_timing_pkg::PULSE_HI_WEIGHT) : '0);
    endfunction
    function automatic logic [CW-1:0] exp_cycle(input logic [strobe_timing_pkg::CYCLE_W-1:0] c);
        logic [CW-1:0] hi;
        hi = CW'(c[8:7]);
        exp_cycle = CW'(c[6:0]) + CW'(hi * CW'(strobe_timing_pkg::CYCLE_HI_WEIGHT));
    endfunction

    // reset release
    logic rst_meta;
    logic rst_sync_n;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // access state
    strobe_timing_pkg::access_state_t state, next_state;
    logic [CW-1:0] count, next_count;
    logic [strobe_timing_pkg::SEL_W-1:0] sel, next_sel;
    logic [strobe_timing_pkg::ADDR_W-1:0] addr, next_addr;
    logic [strobe_timing_pkg::DATA_W-1:0] wdata, next_wdata;
    logic [3:0] lanes, next_lanes;

    // per-select timing of the running access, picked by sel
    logic [CW-1:0] strobe_lead, strobe_width, cs_lead, cs_width, cycle_len;
    logic rmode, wmode, acc_type;
    logic [1:0] bw;
    logic is_write;
    always_comb begin
        is_write = (state == strobe_timing_pkg::ST_WRITE);
        // separate read and write sets, indexed by select
        if (is_write) begin
            strobe_lead = exp_setup(write_strobe_lead_i[sel*strobe_timing_pkg::SETUP_W +: strobe_timing_pkg::SETUP_W]);
            strobe_width = exp_pulse(write_strobe_width_i[sel*strobe_timing_pkg::PULSE_W +: strobe_timing_pkg::PULSE_W]);
            cs_lead = exp_setup(select_write_lead_i[sel*strobe_timing_pkg::SETUP_W +: strobe_timing_pkg::SETUP_W]);
            cs_width = exp_pulse(select_write_width_i[sel*strobe_timing_pkg::PULSE_W +: strobe_timing_pkg::PULSE_W]);
            cycle_len = exp_cycle(write_cycle_length_i[sel*strobe_timing_pkg::CYCLE_W +: strobe_timing_pkg::CYCLE_W]);
        end else begin
            strobe_lead = exp_setup(read_strobe_lead_i[sel*strobe_timing_pkg::SETUP_W +: strobe_timing_pkg::SETUP_W]);
            strobe_width = exp_pulse(read_strobe_width_i[sel*strobe_timing_pkg::PULSE_W +: strobe_timing_pkg::PULSE_W]);
            cs_lead = exp_setup(select_read_lead_i[sel*strobe_timing_pkg::SETUP_W +: strobe_timing_pkg::SETUP_W]);
            cs_width = exp_pulse(select_read_width_i[sel*strobe_timing_pkg::PULSE_W +: strobe_timing_pkg::PULSE_W]);
            cycle_len = exp_cycle(read_cycle_length_i[sel*strobe_timing_pkg::CYCLE_W +: strobe_timing_pkg::CYCLE_W]);
        end
        rmode = read_mode_i[sel];
        wmode = write_mode_i[sel];
        acc_type = byte_access_type_i[sel];
        bw = bus_width_i[sel*2 +: 2];
    end

    strobe_timing_if strobe_t ();
    strobe_timing_if cs_t ();
    assign strobe_t.count = count;
    assign strobe_t.lead = strobe_lead;
    assign strobe_t.width = strobe_width;
    assign strobe_t.length = cycle_len;
    assign strobe_t.active = (state != strobe_timing_pkg::ST_IDLE);
    assign cs_t.count = count;
    assign cs_t.lead = cs_lead;
    assign cs_t.width = cs_width;
    assign cs_t.length = cycle_len;
    assign cs_t.active = (state != strobe_timing_pkg::ST_IDLE);
    strobe_phase u_strobe (.tim(strobe_t));
    strobe_phase u_select (.tim(cs_t));

    // trail is implicit: the access simply ends at cycle_len
    logic last_cycle;
    assign last_cycle = (state != strobe_timing_pkg::ST_IDLE) && (count + CW'(1) >= cycle_len);

    always_comb begin
        next_state = state;
        next_count = count;
        next_sel = sel;
        next_addr = addr;
        next_wdata = wdata;
        next_lanes = lanes;
        if (state == strobe_timing_pkg::ST_IDLE || last_cycle) begin
            next_count = '0;
            if (req_valid_i) begin
                next_state = req_write_i ? strobe_timing_pkg::ST_WRITE : strobe_timing_pkg::ST_READ;
                next_sel = req_sel_i;
                next_addr = req_addr_i;
                next_wdata = req_wdata_i;
                next_lanes = req_lanes_i;
            end else begin
                next_state = strobe_timing_pkg::ST_IDLE;
            end
        end else begin
            next_count = count + CW'(1);
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state <= strobe_timing_pkg::ST_IDLE;
            count <= '0;
            sel <= '0;
            addr <= '0;
            wdata <= '0;
            lanes <= '0;
        end else begin
            state <= next_state;
            count <= next_count;
            sel <= next_sel;
            addr <= next_addr;
            wdata <= next_wdata;
            lanes <= next_lanes;
        end
    end

    // pin values for the coming cycle, registered so pins come from flops
    logic [NSEL-1:0] next_cs_n;
    logic next_rd_n, next_we_n, next_oe, next_rvalid;
    logic sample_pend, next_sample_pend;
    logic [3:0] next_bl;
    logic [strobe_timing_pkg::DATA_W-1:0] next_rdata;
    logic [strobe_timing_pkg::ADDR_W-1:2] next_pin_addr;
    logic [strobe_timing_pkg::DATA_W-1:0] next_dout;
    // strobe and select states at the current count; the pins take them on the next edge
    logic cur_strobe, cur_cs;
    always_comb begin
        cur_strobe = strobe_t.asserted;
        cur_cs = cs_t.asserted;
        next_cs_n = '1;
        next_rd_n = 1'b1;
        next_we_n = 1'b1;
        next_bl = 4'hf;
        next_oe = 1'b0;
        next_pin_addr = addr_o;
        next_dout = data_o;
        next_rvalid = 1'b0;
        next_sample_pend = 1'b0;
        next_rdata = rdata_o;
        if (state != strobe_timing_pkg::ST_IDLE) begin
            next_pin_addr = addr[strobe_timing_pkg::ADDR_W-1:2];
            next_dout = wdata;
            next_cs_n[sel] = !cur_cs;
            if (is_write) begin
                // byte-select and 8-bit writes: write strobe follows the strobe window; byte-write gates it with lane 0 below
                next_we_n = !cur_strobe;
                // data drive window by mode, held to cycle end
                next_oe = wmode ? (count >= strobe_lead) : (count >= cs_lead);
            end else begin
                next_rd_n = !cur_strobe;
            end
            // shared low lines by bus width and access type
            case (bw)
                strobe_timing_pkg::BUS_W8: begin
                    next_bl = {1'b1, addr[1], 1'b1, addr[0]};
                end
                strobe_timing_pkg::BUS_W16: begin
                    if (acc_type == strobe_timing_pkg::BYTE_WRITE) begin
                        next_bl = {1'b1, addr[1], is_write ? !(cur_strobe && lanes[1]) : 1'b1, 1'b1};
                        next_we_n = is_write ? !(cur_strobe && lanes[0]) : 1'b1;
                    end else begin
                        next_bl = {1'b1, addr[1], !lanes[1], !lanes[0]};
                    end
                end
                default: begin
                    if (acc_type == strobe_timing_pkg::BYTE_WRITE) begin
                        next_bl = is_write ? ~({4{cur_strobe}} & lanes) | 4'h1 : 4'hf;
                        next_we_n = is_write ? !(cur_strobe && lanes[0]) : 1'b1;
                    end else begin
                        next_bl = ~lanes;
                    end
                end
            endcase
            // last low count of the chosen strobe; its pin rises two edges later
            if (!is_write
                && count == (rmode ? strobe_lead + strobe_width : cs_lead + cs_width) - CW'(1)) begin
                next_sample_pend = 1'b1;
            end
        end
        // pins still show the last low count here, so memory data is valid; may fall into the next access
        if (sample_pend) begin
            next_rvalid = 1'b1;
            next_rdata = data_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            chip_select_n_o <= '1;
            read_strobe_n_o <= 1'b1;
            write_strobe_n_o <= 1'b1;
            {byte_lane_select3_n_o, byte_lane_select2_n_o, byte_lane_select1_n_o, byte_lane_select0_n_o} <= 4'hf;
            addr_o <= '0;
            data_o <= '0;
            data_oe_o <= 1'b0;
            rdata_valid_o <= 1'b0;
            rdata_o <= '0;
            req_ready_o <= 1'b0;
            sample_pend <= 1'b0;
        end else begin
            chip_select_n_o <= next_cs_n;
            read_strobe_n_o <= next_rd_n;
            write_strobe_n_o <= next_we_n;
            {byte_lane_select3_n_o, byte_lane_select2_n_o, byte_lane_select1_n_o, byte_lane_select0_n_o} <= next_bl;
            addr_o <= next_pin_addr;
            data_o <= next_dout;
            data_oe_o <= next_oe;
            rdata_valid_o <= next_rvalid;
            rdata_o <= next_rdata;
            sample_pend <= next_sample_pend;
            req_ready_o <= (next_state == strobe_timing_pkg::ST_IDLE) || (next_count + CW'(1) >= cycle_len && next_state == state);
        end
    end

    // assertions
    property p_cycle_bound;
        @(posedge sys_clk_i) disable iff (!rst_sync_n)
        (state != strobe_timing_pkg::ST_IDLE) |-> (count < cycle_len || cycle_len == '0);
    endproperty
    a_cycle_bound: assert property (p_cycle_bound) else $error("access ran past cycle length");
    property p_read_low;
        @(posedge sys_clk_i) disable iff (!rst_sync_n)
        (state == strobe_timing_pkg::ST_READ && count == strobe_lead) |=> !read_strobe_n_o;
    endproperty
    a_read_low: assert property (p_read_low) else $error("read strobe not low after lead");
    property p_write_low;
        @(posedge sys_clk_i) disable iff (!rst_sync_n)
        (state == strobe_timing_pkg::ST_WRITE && count == strobe_lead && acc_type == strobe_timing_pkg::BYTE_SELECT)
            |=> !write_strobe_n_o;
    endproperty
    a_write_low: assert property (p_write_low) else $error("write strobe not low after lead");
    property p_no_read_in_write;
        @(posedge sys_clk_i) disable iff (!rst_sync_n) data_oe_o |-> read_strobe_n_o;
    endproperty
    a_no_read_in_write: assert property (p_no_read_in_write) else $error("read strobe during write");
    property p_oe_mode0;
        @(posedge sys_clk_i) disable iff (!rst_sync_n)
        (is_write && !wmode && count >= cs_lead) |=> data_oe_o;
    endproperty
    a_oe_mode0: assert property (p_oe_mode0) else $error("data not driven after select lead");
    property p_sample_read_only;
        @(posedge sys_clk_i) disable iff (!rst_sync_n) rdata_valid_o |-> $past(state, 2) == strobe_timing_pkg::ST_READ;
    endproperty
    a_sample_read_only: assert property (p_sample_read_only) else $error("sample outside read");
    property p_idle_pins;
        @(posedge sys_clk_i) disable iff (!rst_sync_n)
        (state == strobe_timing_pkg::ST_IDLE) |=> (chip_select_n_o == '1 && read_strobe_n_o);
    endproperty
    a_idle_pins: assert property (p_idle_pins) else $error("strobes active while idle");
    property p_one_select;
        @(posedge sys_clk_i) disable iff (!rst_sync_n) $countones(~chip_select_n_o) <= 1;
    endproperty
    a_one_select: assert property (p_one_select) else $error("two selects low");
    c_read: cover property (@(posedge sys_clk_i) rdata_valid_o);
    c_write: cover property (@(posedge sys_clk_i) data_oe_o && !write_strobe_n_o);
    c_b2b: cover property (@(posedge sys_clk_i) last_cycle && req_valid_i);
endmodule
`default_nettype wire

// ===== strobe_phase.sv
`default_nettype none
// one strobe: asserted while lead <= count < lead + width
module strobe_phase (
    strobe_timing_if.gen tim
);
    logic [strobe_timing_pkg::COUNT_W:0] edge_end;
    always_comb begin
        edge_end = {1'b0, tim.lead} + {1'b0, tim.width};
        tim.asserted = tim.active && ({1'b0, tim.count} >= {1'b0, tim.lead})
            && ({1'b0, tim.count} < edge_end);
    end
endmodule
`default_nettype wire

// ===== strobe_timing_if.sv
`default_nettype none
interface strobe_timing_if;
    logic [strobe_timing_pkg::COUNT_W-1:0] count;
    logic [strobe_timing_pkg::COUNT_W-1:0] lead;
    logic [strobe_timing_pkg::COUNT_W-1:0] width;
    logic [strobe_timing_pkg::COUNT_W-1:0] length;
    logic active;
    logic asserted;
    modport ctrl (output count, output lead, output width, output length, output active, input asserted);
    modport gen (input count, input lead, input width, input length, input active, output asserted);
endinterface
`default_nettype wire

// ===== strobe_timing_pkg.sv
`default_nettype none
package strobe_timing_pkg;
    localparam int NUM_SELECTS = 8;
    localparam int SEL_W = 3;
    localparam int ADDR_W = 26;
    localparam int DATA_W = 32;
    localparam int SETUP_W = 6;
    localparam int PULSE_W = 7;
    localparam int CYCLE_W = 9;
    localparam int COUNT_W = 10;
    // setup code: bit 5 weighs 128, bits 4:0 plain
    localparam int SETUP_HI_BIT = 5;
    localparam int SETUP_HI_WEIGHT = 128;
    // pulse code: bit 6 weighs 256, bits 5:0 plain
    localparam int PULSE_HI_BIT = 6;
    localparam int PULSE_HI_WEIGHT = 256;
    // cycle code: bits 8:7 weigh 256, bits 6:0 plain
    localparam int CYCLE_HI_LSB = 7;
    localparam int CYCLE_HI_WEIGHT = 256;
    // reset timing values
    localparam logic [SETUP_W-1:0] SETUP_RESET = 6'h00;
    localparam logic [PULSE_W-1:0] PULSE_RESET = 7'h01;
    localparam logic [CYCLE_W-1:0] CYCLE_RESET = 9'h003;
    localparam logic MODE_RESET = 1'b0;
    // data bus width codes
    localparam logic [1:0] BUS_W8 = 2'h0;
    localparam logic [1:0] BUS_W16 = 2'h1;
    localparam logic [1:0] BUS_W32 = 2'h2;
    // byte access type codes
    localparam logic BYTE_SELECT = 1'b0;
    localparam logic BYTE_WRITE = 1'b1;
    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} access_state_t;
endpackage
`default_nettype wire

// ===== tb_static_memory_strobe_timing.sv
`default_nettype none
module tb_static_memory_strobe_timing;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic w;
        logic [2:0] sel;
        logic [25:0] addr;
        logic [31:0] wd;
        logic [3:0] ln;
    } req_t;
    localparam logic [47:0] S0 = {8{strobe_timing_pkg::SETUP_RESET}};
    localparam logic [55:0] P0 = {8{strobe_timing_pkg::PULSE_RESET}};
    localparam logic [71:0] C0 = {8{strobe_timing_pkg::CYCLE_RESET}};
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [47:0] rsl = S0, csrl = S0, wsl = S0, cswl = S0;
    logic [55:0] rsw = P0, csrw = P0, wsw = P0, csww = P0;
    logic [71:0] rcyc = C0, wcyc = C0;
    logic [7:0] rmode = {8{strobe_timing_pkg::MODE_RESET}}, wmode = {8{strobe_timing_pkg::MODE_RESET}};
    logic [15:0] bw = {8{strobe_timing_pkg::BUS_W32}};
    logic [7:0] acc_type = {8{strobe_timing_pkg::BYTE_SELECT}};
    req_t rq = '0;
    req_t cur, chk_r;
    logic req_valid_i = 1'b0;
    logic busy = 1'b0, chk_on = 1'b0, rv = 1'b0;
    int k, len, chk_n, take_cnt, cyc, error_cnt, checked;
    logic [31:0] rv_exp, rdata_o, data_i, data_o;
    logic [31:0] shadow [16];
    logic req_ready_o, rdata_valid_o, read_strobe_n_o, write_strobe_n_o, data_oe_o, bs0, bs1, bs2, bs3;
    logic [7:0] chip_select_n_o;
    logic [23:0] addr_o;

    static_memory_strobe_timing dut (
        .sys_clk_i, .rst_n_i, .read_strobe_lead_i(rsl), .read_strobe_width_i(rsw),
        .select_read_lead_i(csrl), .select_read_width_i(csrw), .read_cycle_length_i(rcyc),
        .write_strobe_lead_i(wsl), .write_strobe_width_i(wsw), .select_write_lead_i(cswl),
        .select_write_width_i(csww), .write_cycle_length_i(wcyc), .read_mode_i(rmode), .write_mode_i(wmode),
        .bus_width_i(bw), .byte_access_type_i(acc_type), .req_valid_i, .req_write_i(rq.w), .req_sel_i(rq.sel),
        .req_addr_i(rq.addr), .req_wdata_i(rq.wd), .req_lanes_i(rq.ln), .req_ready_o, .rdata_valid_o,
        .rdata_o, .chip_select_n_o, .read_strobe_n_o, .write_strobe_n_o, .byte_lane_select0_n_o(bs0),
        .byte_lane_select1_n_o(bs1), .byte_lane_select2_n_o(bs2), .byte_lane_select3_n_o(bs3),
        .addr_o, .data_i, .data_o, .data_oe_o
    );
    mem_model mem (.sys_clk_i, .chip_select_n_i(chip_select_n_o), .read_strobe_n_i(read_strobe_n_o),
        .write_strobe_n_i(write_strobe_n_o), .addr_i(addr_o), .data_i(data_o), .data_oe_i(data_oe_o),
        .data_o(data_i));

    initial forever #12.5 sys_clk_i = ~sys_clk_i;

    function automatic int es(input logic [5:0] c);
        return 128 * c[5] + c[4:0];
    endfunction
    function automatic int ep(input logic [6:0] c);
        return 256 * c[6] + c[5:0];
    endfunction
    function automatic int ec(input logic [8:0] c);
        return 256 * c[8:7] + c[6:0];
    endfunction
    task automatic final_report();
        if (error_cnt == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cfg(input int s, input logic [5:0] rl, cl, wl, xl, input logic [6:0] rw, cw, ww, xw,
            input logic [8:0] rc, wc, input logic rm, wm, input logic [1:0] w, input logic t);
        rsl[s*6 +: 6] = rl;
        csrl[s*6 +: 6] = cl;
        wsl[s*6 +: 6] = wl;
        cswl[s*6 +: 6] = xl;
        rsw[s*7 +: 7] = rw;
        csrw[s*7 +: 7] = cw;
        wsw[s*7 +: 7] = ww;
        csww[s*7 +: 7] = xw;
        rcyc[s*9 +: 9] = rc;
        wcyc[s*9 +: 9] = wc;
        rmode[s] = rm;
        wmode[s] = wm;
        bw[s*2 +: 2] = w;
        acc_type[s] = t;
    endtask
    // pins as they should stand at count n of access r
    task automatic check_pins(input req_t r, input int n);
        int s, sl, sw, cl, cw;
        logic slo, clo, bwr, oe;
        logic [7:0] ecs;
        logic [3:0] el, m, wl;
        s = r.sel;
        sl = es(r.w ? wsl[s*6 +: 6] : rsl[s*6 +: 6]);
        sw = ep(r.w ? wsw[s*7 +: 7] : rsw[s*7 +: 7]);
        cl = es(r.w ? cswl[s*6 +: 6] : csrl[s*6 +: 6]);
        cw = ep(r.w ? csww[s*7 +: 7] : csrw[s*7 +: 7]);
        slo = n >= sl && n < sl + sw;
        clo = n >= cl && n < cl + cw;
        ecs = 8'hff;
        ecs[s] = !clo;
        bwr = acc_type[s] == strobe_timing_pkg::BYTE_WRITE && bw[s*2 +: 2] != strobe_timing_pkg::BUS_W8;
        wl = r.ln & {4{r.w && slo}};
        el = bwr ? {~wl[3:1], 1'b1} : ~r.ln;
        m = 4'hf;
        if (bw[s*2 +: 2] == strobe_timing_pkg::BUS_W16) begin
            el[2] = r.addr[1];
            m = bwr ? 4'h6 : 4'h7;
        end
        if (bw[s*2 +: 2] == strobe_timing_pkg::BUS_W8) begin
            el = {1'b0, r.addr[1], 1'b0, r.addr[0]};
            m = 4'h5;
        end
        oe = r.w && n >= (wmode[s] ? sl : cl);
        cmp(chip_select_n_o, ecs);
        cmp(read_strobe_n_o, !(slo && !r.w));
        cmp(write_strobe_n_o, !(slo && r.w && (r.ln[0] || !bwr)));
        cmp(addr_o, r.addr[25:2]);
        cmp({bs3, bs2, bs1, bs0} & m, el & m);
        cmp(data_oe_o, oe);
        if (oe) cmp(data_o, r.wd);
        if (!r.w && n == (rmode[s] ? sl + sw - 1 : cl + cw - 1)) begin
            rv = 1'b1;
            rv_exp = shadow[r.addr[5:2]];
        end
    endtask
    // pins are registered, so each edge sees the count set up two edges before
    always @(posedge sys_clk_i) begin
        cyc++;
        if (rv) begin
            cmp(rdata_valid_o, 1'b1);
            cmp(rdata_o, rv_exp);
        end
        rv = 1'b0;
        if (chk_on) check_pins(chk_r, chk_n);
        chk_on = 1'b0;
        // ready seen here belongs to the cycle just ended: idle or its last count
        if (busy || req_valid_i) cmp(req_ready_o, !busy || k == len - 1);
        if (busy) begin
            k++;
            chk_on = 1'b1;
            chk_r = cur;
            chk_n = k - 1;
            busy = k < len;
        end
        if (!busy && req_valid_i) begin
            cur = rq;
            busy = 1'b1;
            k = 0;
            len = ec(rq.w ? wcyc[rq.sel*9 +: 9] : rcyc[rq.sel*9 +: 9]);
            take_cnt++;
            if (rq.w) shadow[rq.addr[5:2]] = rq.wd;
        end
        if (cyc == 8000) begin
            error_cnt++;
            final_report();
        end
    end
    // request stays up after the take, ready for a back-to-back follower
    task automatic issue(input req_t r);
        int c0;
        c0 = take_cnt;
        rq = r;
        req_valid_i = 1'b1;
        while (take_cnt == c0) begin
            @(posedge sys_clk_i);
            #1;
        end
        #1;
    endtask

    initial begin
        for (int i = 0; i < 16; i++) begin
            shadow[i] = 32'h5a000000 + i;
        end
        repeat (2) @(posedge sys_clk_i);
        #2;
        cmp(chip_select_n_o, 8'hff);
        cmp(data_oe_o, 1'b0);
        rst_n_i = 1'b1;
        repeat (4) @(posedge sys_clk_i);
        #2;
        issue('{1'b1, 3'h0, 26'h10, 32'hc0de0001, 4'hf});
        issue('{1'b0, 3'h0, 26'h10, 32'h0, 4'hf});
        cfg(1, 6'h01, 6'h00, 6'h02, 6'h01, 7'h01, 7'h04, 7'h02, 7'h03, 9'h006, 9'h006, 1'b1, 1'b1,
            strobe_timing_pkg::BUS_W32, strobe_timing_pkg::BYTE_SELECT);
        issue('{1'b1, 3'h1, 26'h14, 32'h0badf00d, 4'hf});
        issue('{1'b0, 3'h1, 26'h14, 32'h0, 4'hf});
        cfg(2, 6'h00, 6'h01, 6'h01, 6'h00, 7'h04, 7'h01, 7'h02, 7'h04, 9'h005, 9'h005, 1'b0, 1'b0,
            strobe_timing_pkg::BUS_W16, strobe_timing_pkg::BYTE_SELECT);
        issue('{1'b1, 3'h2, 26'h1a, 32'h12345678, 4'h3});
        issue('{1'b0, 3'h2, 26'h1a, 32'h0, 4'h3});
        cfg(3, 6'h00, 6'h00, 6'h00, 6'h00, 7'h03, 7'h03, 7'h03, 7'h03, 9'h003, 9'h003, 1'b0, 1'b0,
            strobe_timing_pkg::BUS_W8, strobe_timing_pkg::BYTE_SELECT);
        issue('{1'b1, 3'h3, 26'h1d, 32'ha5a5a5a5, 4'hf});
        issue('{1'b1, 3'h3, 26'h22, 32'h3c3c3c3c, 4'hf});
        issue('{1'b0, 3'h3, 26'h1d, 32'h0, 4'hf});
        issue('{1'b0, 3'h3, 26'h22, 32'h0, 4'hf});
        cfg(4, 6'h00, 6'h00, 6'h00, 6'h00, 7'h01, 7'h01, 7'h01, 7'h01, 9'h003, 9'h003, 1'b0, 1'b0,
            strobe_timing_pkg::BUS_W16, strobe_timing_pkg::BYTE_WRITE);
        issue('{1'b1, 3'h4, 26'h24, 32'h00c0ffee, 4'h3});
        issue('{1'b0, 3'h4, 26'h24, 32'h0, 4'h3});
        issue('{1'b1, 3'h4, 26'h3c, 32'h11112222, 4'h2});
        issue('{1'b1, 3'h5, 26'h3c, 32'h33334444, 4'h5});
        cfg(7, 6'h00, 6'h00, 6'h00, 6'h00, 7'h01, 7'h01, 7'h01, 7'h01, 9'h003, 9'h003, 1'b0, 1'b0,
            strobe_timing_pkg::BUS_W32, strobe_timing_pkg::BYTE_WRITE);
        issue('{1'b1, 3'h7, 26'h3c, 32'h55556666, 4'ha});
        issue('{1'b1, 3'h7, 26'h28, 32'h77778888, 4'hf});
        issue('{1'b0, 3'h7, 26'h28, 32'h0, 4'hf});
        cfg(6, 6'h21, 6'h00, 6'h00, 6'h00, 7'h01, 7'h41, 7'h01, 7'h01, 9'h102, 9'h003, 1'b1, 1'b0,
            strobe_timing_pkg::BUS_W32, strobe_timing_pkg::BYTE_SELECT);
        issue('{1'b0, 3'h6, 26'h10, 32'h0, 4'hf});
        req_valid_i = 1'b0;
        repeat (520) @(posedge sys_clk_i);
        final_report();
    end
endmodule
`default_nettype wire
